// [rtl/gcr_if.sv]
// Byte access path and decoded fields between serial slave and register file.
// Assumes both ends run on sys_clk.
`timescale 1ns/1ps
`default_nettype none
interface gcr_if;
    logic        wr_en;
    logic [15:0] wr_addr;
    logic [7:0]  wdata;
    logic [15:0] rd_addr;
    logic [7:0]  rdata;
    logic [15:0] slope;
    logic [31:0] ctrl;
    logic [13:0] sel;
    modport host (output wr_en, wr_addr, wdata, rd_addr,
                  input rdata, slope, ctrl, sel);
    modport regs (input wr_en, wr_addr, wdata, rd_addr,
                  output rdata, slope, ctrl, sel);
endinterface : gcr_if
`default_nettype wire

// [rtl/gcr_pkg.sv]
// Constants, register map and state codes of the gauge configuration bank.
// Assumes a byte-addressed host map with 16-bit register addresses.
package gcr_pkg;
    // Byte addresses; 16-bit fields are stored low byte first
    localparam logic [15:0] ADDR_SLOPE_LO = 16'h1008;
    localparam logic [15:0] ADDR_SLOPE_HI = 16'h1009;
    localparam logic [15:0] ADDR_CTRL_B0  = 16'h1100;
    localparam logic [15:0] ADDR_CTRL_B1  = 16'h1101;
    localparam logic [15:0] ADDR_CTRL_B2  = 16'h1102;
    localparam logic [15:0] ADDR_CTRL_B3  = 16'h1103;
    localparam logic [15:0] ADDR_SEL_B0   = 16'h1200;
    localparam logic [15:0] ADDR_SEL_B1   = 16'h1201;
    // Slope default 0.001 %/s at 0.00005 %/s per step = 20 steps
    localparam logic [15:0] SLOPE_RESET   = 16'h0014;
    // Control word: implemented bits and their reset value
    localparam logic [31:0] CTRL_MASK     = 32'h000c_fc8f;
    localparam logic [31:0] CTRL_RESET    = 32'h000c_fc8f;
    localparam int          BIT_PACK_V    = 0;
    localparam int          BIT_PACK_I    = 1;
    localparam int          BIT_CELL_I    = 2;
    localparam int          BIT_COULOMB   = 3;
    localparam int          BIT_HEALTH    = 7;
    localparam int          BIT_CHG_CC    = 10;
    localparam int          BIT_CHG_END   = 11;
    localparam int          BIT_CHG_CV    = 12;
    localparam int          BIT_DIS_AVG   = 13;
    localparam int          BIT_DIS_END   = 14;
    localparam int          BIT_DIS_CONT  = 15;
    localparam int          BIT_PCHG      = 18;
    localparam int          BIT_PDIS      = 19;
    // Sensor selectors: seven cells, two bits each, stored value 0 = sensor 1
    localparam int          CELLS         = 7;
    localparam int          SEL_W         = 2;
    localparam logic [13:0] SEL_RESET     = 14'h0000;
    localparam logic [2:0]  SENSOR_OFFSET = 3'h1;
    localparam logic [7:0]  UNMAPPED_RD   = 8'h00;
    localparam logic [2:0]  LAST_BIT      = 3'h7;
    // Host serial slave states
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_DEV  = 4'h1,
        ST_HI   = 4'h2,
        ST_LO   = 4'h3,
        ST_WR   = 4'h4,
        ST_ACK  = 4'h5,
        ST_RD   = 4'h6,
        ST_RACK = 4'h7
    } gcr_state_e;
endpackage : gcr_pkg

// [rtl/gcr_regfile.sv]
// Configuration storage: slope limit, control word and sensor selectors.
// Assumes single-byte writes and a registered byte read port.
`timescale 1ns/1ps
`default_nettype none
module gcr_regfile (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    gcr_if.regs       bus
);
    logic [15:0] slope;
    logic [31:0] ctrl;
    logic [13:0] sel;
    // Byte writes; unimplemented bits and addresses are dropped
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            slope <= gcr_pkg::SLOPE_RESET;
            ctrl  <= gcr_pkg::CTRL_RESET;
            sel   <= gcr_pkg::SEL_RESET;
        end
        else if (bus.wr_en)
        begin
            case (bus.wr_addr)
                gcr_pkg::ADDR_SLOPE_LO: slope[7:0]   <= bus.wdata;
                gcr_pkg::ADDR_SLOPE_HI: slope[15:8]  <= bus.wdata;
                gcr_pkg::ADDR_CTRL_B0:  ctrl[7:0]    <= bus.wdata & gcr_pkg::CTRL_MASK[7:0];
                gcr_pkg::ADDR_CTRL_B1:  ctrl[15:8]   <= bus.wdata & gcr_pkg::CTRL_MASK[15:8];
                gcr_pkg::ADDR_CTRL_B2:  ctrl[23:16]  <= bus.wdata & gcr_pkg::CTRL_MASK[23:16];
                gcr_pkg::ADDR_CTRL_B3:  ctrl[31:24]  <= bus.wdata & gcr_pkg::CTRL_MASK[31:24];
                gcr_pkg::ADDR_SEL_B0:   sel[7:0]     <= bus.wdata;
                gcr_pkg::ADDR_SEL_B1:   sel[13:8]    <= bus.wdata[5:0];
                default:                slope        <= slope;
            endcase
        end
    end

    // Registered read; unmapped bytes read zero
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            bus.rdata <= gcr_pkg::UNMAPPED_RD;
        else
        begin
            case (bus.rd_addr)
                gcr_pkg::ADDR_SLOPE_LO: bus.rdata <= slope[7:0];
                gcr_pkg::ADDR_SLOPE_HI: bus.rdata <= slope[15:8];
                gcr_pkg::ADDR_CTRL_B0:  bus.rdata <= ctrl[7:0];
                gcr_pkg::ADDR_CTRL_B1:  bus.rdata <= ctrl[15:8];
                gcr_pkg::ADDR_CTRL_B2:  bus.rdata <= ctrl[23:16];
                gcr_pkg::ADDR_CTRL_B3:  bus.rdata <= ctrl[31:24];
                gcr_pkg::ADDR_SEL_B0:   bus.rdata <= sel[7:0];
                gcr_pkg::ADDR_SEL_B1:   bus.rdata <= {2'h0, sel[13:8]};
                default:                bus.rdata <= gcr_pkg::UNMAPPED_RD;
            endcase
        end
    end

    assign bus.slope = slope;
    assign bus.ctrl  = ctrl;
    assign bus.sel   = sel;
endmodule : gcr_regfile
`default_nettype wire

// [rtl/gcr_sync.sv]
// Two-flop synchronisers for asynchronous pin inputs, one per bit.
// Assumes idle-high lines (open-drain bus), so reset value is 1.
`timescale 1ns/1ps
`default_nettype none
module gcr_sync #(
    parameter int W = 2
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    if (W < 1)
    begin : g_bad_w
        $error("W must be at least 1");
    end
    // First stage feeds only the second stage
    for (genvar i = 0; i < W; i++)
    begin : g_bit
        logic meta;
        always_ff @(posedge sys_clk)
        begin
            if (!rst_n)
            begin
                meta <= 1'b1;
                q[i] <= 1'b1;
            end
            else
            begin
                meta <= d[i];
                q[i] <= meta;
            end
        end
    end
endmodule : gcr_sync
`default_nettype wire

// [rtl/gcr_top.sv]
// Gauge configuration bank behind a two-wire serial host port.
// Assumes the host drives the serial clock well below sys_clk / 8 and
// pulls both lines up externally; no clock stretching is done.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Rest slope limit is 16 bits at 0x1008, step 0.00005 %/s, default 0.001.
// - Control word bit 0 enables pack voltage input, reset 1.
// - Control word bit 1 enables pack current input, reset 1.
// - Control word bit 2 enables per-cell current inputs, reset 1.
// - Control word bit 3 enables coulomb counting input, reset 1.
// - Control word bit 10 enables constant-current charge learning, reset 1.
// - Control word bit 11 enables charge termination current learning, reset 1.
// - Control word bit 12 enables constant-voltage charge learning, reset 1.
// - Control word bit 13 enables average discharge current learning, reset 1.
// - Control word bit 14 enables discharge termination current learning, reset 1.
// - Control word bit 15 enables continuous discharge termination learning, reset 1.
// - Control word bit 18 gives charge-power indicator default, reset 1.
// - Control word bit 19 gives discharge-power indicator default, reset 1.
// - Each selector is two bits; sensor number is value plus one; default sensor 1.
// - Cells 1 to 4 selectors sit in byte 0x1200, low pairs first.
// - Cells 5 to 7 selectors sit in bits 5:0 of byte 0x1201.
module gcr_top #(
    parameter logic [6:0] DEV_ADDR = 7'h08  // Arbitrary bus address
) (
    input  wire logic                            sys_clk,
    input  wire logic                            rst_n,
    input  wire logic                            scl_in,
    input  wire logic                            sda_in,
    output var  logic                            sda_out,
    output var  logic                            sda_oe,
    output var  logic [15:0]                     rest_soc_slope_limit,
    output var  logic                            pack_voltage_input_enable,
    output var  logic                            pack_current_input_enable,
    output var  logic                            cell_current_input_enable,
    output var  logic                            charge_counter_input_enable,
    output var  logic                            health_learning_enable,
    output var  logic                            charge_constant_current_learn_enable,
    output var  logic                            charge_termination_learn_enable,
    output var  logic                            charge_constant_voltage_learn_enable,
    output var  logic                            discharge_average_learn_enable,
    output var  logic                            discharge_termination_learn_enable,
    output var  logic                            discharge_termination_continuous_enable,
    output var  logic                            charge_power_indicator_default,
    output var  logic                            discharge_power_indicator_default,
    output var  logic [gcr_pkg::CELLS-1:0][1:0] cell_sensor_select,
    output var  logic [gcr_pkg::CELLS-1:0][2:0] cell_sensor_number
);
    // Refuse a reserved or ten-bit style bus address
    if (DEV_ADDR < 7'h08 || DEV_ADDR > 7'h77)
    begin : g_bad_addr
        $error("DEV_ADDR outside the usable 7-bit range");
    end

    gcr_if bus ();

    gcr_pkg::gcr_state_e state;
    gcr_pkg::gcr_state_e after_ack;
    logic [1:0]          pins_s;
    logic                scl_s;
    logic                sda_s;
    logic                scl_d;
    logic                sda_d;
    logic                scl_rise;
    logic                scl_fall;
    logic                start_det;
    logic                stop_det;
    logic [7:0]          shreg;
    logic [2:0]          bit_cnt;
    logic                byte_done;
    logic                nack;
    logic [15:0]         ptr;
    logic                addr_match;
    logic                rx_state;
    logic                byte_end;

    // Pin synchronisers
    gcr_sync #(
        .W (2)
    ) u_sync (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .d       ({scl_in, sda_in}),
        .q       (pins_s)
    );

    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    // Previous synchronised levels for edge detection
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    // Line events
    assign scl_rise  = scl_s & ~scl_d;
    assign scl_fall  = ~scl_s & scl_d;
    assign start_det = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;

    // Byte decode helpers
    assign addr_match = (shreg[7:1] == DEV_ADDR);
    assign rx_state   = (state == gcr_pkg::ST_DEV) || (state == gcr_pkg::ST_HI) ||
                        (state == gcr_pkg::ST_LO) || (state == gcr_pkg::ST_WR);
    assign byte_end   = scl_fall & byte_done;

    // Transfer sequencing: address, pointer bytes, then data bytes
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            state     <= gcr_pkg::ST_IDLE;
            after_ack <= gcr_pkg::ST_IDLE;
        end
        else if (start_det)
            state <= gcr_pkg::ST_DEV;
        else if (stop_det)
            state <= gcr_pkg::ST_IDLE;
        else
        begin
            case (state)
                gcr_pkg::ST_DEV:
                begin
                    if (byte_end)
                    begin
                        state     <= addr_match ? gcr_pkg::ST_ACK : gcr_pkg::ST_IDLE;
                        after_ack <= shreg[0] ? gcr_pkg::ST_RD : gcr_pkg::ST_HI;
                    end
                end
                gcr_pkg::ST_HI:
                begin
                    if (byte_end)
                    begin
                        state     <= gcr_pkg::ST_ACK;
                        after_ack <= gcr_pkg::ST_LO;
                    end
                end
                gcr_pkg::ST_LO, gcr_pkg::ST_WR:
                begin
                    if (byte_end)
                    begin
                        state     <= gcr_pkg::ST_ACK;
                        after_ack <= gcr_pkg::ST_WR;
                    end
                end
                gcr_pkg::ST_ACK:
                begin
                    if (scl_fall)
                        state <= after_ack;
                end
                gcr_pkg::ST_RD:
                begin
                    if (byte_end)
                        state <= gcr_pkg::ST_RACK;
                end
                gcr_pkg::ST_RACK:
                begin
                    if (scl_fall)
                        state <= nack ? gcr_pkg::ST_IDLE : gcr_pkg::ST_RD;
                end
                gcr_pkg::ST_IDLE:
                    state <= gcr_pkg::ST_IDLE;
                default:
                    state <= gcr_pkg::ST_IDLE;
            endcase
        end
    end

    // Bit counter and byte-complete flag
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            bit_cnt   <= 3'h0;
            byte_done <= 1'b0;
        end
        else if (start_det || stop_det || byte_end)
        begin
            bit_cnt   <= 3'h0;
            byte_done <= 1'b0;
        end
        else if (scl_rise && (rx_state || state == gcr_pkg::ST_RD))
        begin
            bit_cnt   <= bit_cnt + 3'h1;
            byte_done <= (bit_cnt == gcr_pkg::LAST_BIT);
        end
    end

    // Shift register: samples on rising clock, reloads for reads
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            shreg <= 8'h00;
        else if (rx_state && scl_rise)
            shreg <= {shreg[6:0], sda_s};
        else if (scl_fall && state == gcr_pkg::ST_ACK && after_ack == gcr_pkg::ST_RD)
            shreg <= bus.rdata;
        else if (scl_fall && state == gcr_pkg::ST_RACK && !nack)
            shreg <= bus.rdata;
        else if (scl_fall && state == gcr_pkg::ST_RD && !byte_done)
            shreg <= {shreg[6:0], 1'b1};
    end

    // Host acknowledge of each read byte
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            nack <= 1'b1;
        else if (state == gcr_pkg::ST_RACK && scl_rise)
            nack <= sda_s;
    end

    // Register pointer: loaded from two address bytes, steps per data byte
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            ptr <= 16'h0000;
        else if (byte_end && state == gcr_pkg::ST_HI)
            ptr[15:8] <= shreg;
        else if (byte_end && state == gcr_pkg::ST_LO)
            ptr[7:0] <= shreg;
        else if (byte_end && (state == gcr_pkg::ST_WR || state == gcr_pkg::ST_RD))
            ptr <= ptr + 16'h0001;
    end

    // Byte write strobe to the register file
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            bus.wr_en   <= 1'b0;
            bus.wr_addr <= 16'h0000;
            bus.wdata   <= 8'h00;
        end
        else
        begin
            bus.wr_en   <= byte_end && (state == gcr_pkg::ST_WR);
            bus.wr_addr <= ptr;
            bus.wdata   <= shreg;
        end
    end

    assign bus.rd_addr = ptr;

    // Data line drive: acknowledge slots and read data bits
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            sda_oe <= 1'b0;
        else if (start_det || stop_det)
            sda_oe <= 1'b0;
        else if (scl_fall)
        begin
            case (state)
                gcr_pkg::ST_DEV:
                    sda_oe <= byte_done && addr_match;
                gcr_pkg::ST_HI, gcr_pkg::ST_LO, gcr_pkg::ST_WR:
                    sda_oe <= byte_done;
                gcr_pkg::ST_ACK:
                    sda_oe <= (after_ack == gcr_pkg::ST_RD) && !bus.rdata[7];
                gcr_pkg::ST_RD:
                    sda_oe <= !byte_done && !shreg[6];
                gcr_pkg::ST_RACK:
                    sda_oe <= !nack && !bus.rdata[7];
                default:
                    sda_oe <= 1'b0;
            endcase
        end
    end

    // Open-drain: only ever pulls low
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            sda_out <= 1'b0;
        else
            sda_out <= 1'b0;
    end

    gcr_regfile u_regs (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .bus     (bus)
    );

    // Field outputs, registered from the stored slope limit and control word
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            rest_soc_slope_limit                    <= gcr_pkg::SLOPE_RESET;
            pack_voltage_input_enable               <= gcr_pkg::CTRL_RESET[gcr_pkg::BIT_PACK_V];
            pack_current_input_enable               <= gcr_pkg::CTRL_RESET[gcr_pkg::BIT_PACK_I];
            cell_current_input_enable               <= gcr_pkg::CTRL_RESET[gcr_pkg::BIT_CELL_I];
            charge_counter_input_enable             <= gcr_pkg::CTRL_RESET[gcr_pkg::BIT_COULOMB];
            health_learning_enable                  <= gcr_pkg::CTRL_RESET[gcr_pkg::BIT_HEALTH];
            charge_constant_current_learn_enable    <= gcr_pkg::CTRL_RESET[gcr_pkg::BIT_CHG_CC];
            charge_termination_learn_enable         <= gcr_pkg::CTRL_RESET[gcr_pkg::BIT_CHG_END];
            charge_constant_voltage_learn_enable    <= gcr_pkg::CTRL_RESET[gcr_pkg::BIT_CHG_CV];
            discharge_average_learn_enable          <= gcr_pkg::CTRL_RESET[gcr_pkg::BIT_DIS_AVG];
            discharge_termination_learn_enable      <= gcr_pkg::CTRL_RESET[gcr_pkg::BIT_DIS_END];
            discharge_termination_continuous_enable <= gcr_pkg::CTRL_RESET[gcr_pkg::BIT_DIS_CONT];
            charge_power_indicator_default          <= gcr_pkg::CTRL_RESET[gcr_pkg::BIT_PCHG];
            discharge_power_indicator_default       <= gcr_pkg::CTRL_RESET[gcr_pkg::BIT_PDIS];
        end
        else
        begin
            rest_soc_slope_limit                    <= bus.slope;
            pack_voltage_input_enable               <= bus.ctrl[gcr_pkg::BIT_PACK_V];
            pack_current_input_enable               <= bus.ctrl[gcr_pkg::BIT_PACK_I];
            cell_current_input_enable               <= bus.ctrl[gcr_pkg::BIT_CELL_I];
            charge_counter_input_enable             <= bus.ctrl[gcr_pkg::BIT_COULOMB];
            health_learning_enable                  <= bus.ctrl[gcr_pkg::BIT_HEALTH];
            charge_constant_current_learn_enable    <= bus.ctrl[gcr_pkg::BIT_CHG_CC];
            charge_termination_learn_enable         <= bus.ctrl[gcr_pkg::BIT_CHG_END];
            charge_constant_voltage_learn_enable    <= bus.ctrl[gcr_pkg::BIT_CHG_CV];
            discharge_average_learn_enable          <= bus.ctrl[gcr_pkg::BIT_DIS_AVG];
            discharge_termination_learn_enable      <= bus.ctrl[gcr_pkg::BIT_DIS_END];
            discharge_termination_continuous_enable <= bus.ctrl[gcr_pkg::BIT_DIS_CONT];
            charge_power_indicator_default          <= bus.ctrl[gcr_pkg::BIT_PCHG];
            discharge_power_indicator_default       <= bus.ctrl[gcr_pkg::BIT_PDIS];
        end
    end

    // Per-cell selector and decoded sensor number (value plus one)
    for (genvar c = 0; c < gcr_pkg::CELLS; c++)
    begin : g_cell
        always_ff @(posedge sys_clk)
        begin
            if (!rst_n)
            begin
                cell_sensor_select[c] <= gcr_pkg::SEL_RESET[c*gcr_pkg::SEL_W +: 2];
                cell_sensor_number[c] <= gcr_pkg::SENSOR_OFFSET;
            end
            else
            begin
                cell_sensor_select[c] <= bus.sel[c*gcr_pkg::SEL_W +: 2];
                cell_sensor_number[c] <= {1'b0, bus.sel[c*gcr_pkg::SEL_W +: 2]}
                                         + gcr_pkg::SENSOR_OFFSET;
            end
        end
    end
endmodule : gcr_top
`default_nettype wire

// [verif/gcr_host.sv]
// Host model: two-wire bus master driving the clock and an open-drain data line.
// Assumes a pull-up on the data line, so a released line reads 1.
`timescale 1ns/1ps
`default_nettype none
module gcr_host (
    input  wire logic sys_clk,
    input  wire logic sda,
    output var  logic scl,
    output var  logic sda_o
);
    initial
    begin
        scl = 1'b1;
        sda_o = 1'b1;
    end
    // Half bit period of 10 system clocks, changed at the falling edge
    task automatic hp;
        repeat (10) @(negedge sys_clk);
    endtask : hp
    // Start or repeated start: data falls while clock is high
    task automatic start;
        sda_o = 1'b1; hp(); scl = 1'b1; hp(); sda_o = 1'b0; hp(); scl = 1'b0;
    endtask : start
    task automatic stop;
        sda_o = 1'b0; hp(); scl = 1'b1; hp(); sda_o = 1'b1; hp();
    endtask : stop
    // Nine bit slots, msb first; q holds the line as seen at the end of each high phase
    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--)
        begin
            sda_o = d[i]; hp(); scl = 1'b1; hp(); q[i] = sda; scl = 1'b0;
        end
    endtask : xfer
endmodule : gcr_host
`default_nettype wire

// [verif/gcr_top_properties.sv]
// Checker on the ports of the gauge configuration bank.
// Assumes one clock domain and the two-wire pins seen after the top's inputs.
`timescale 1ns/1ps
`default_nettype none
module gcr_props (
    input wire logic                            sys_clk,
    input wire logic                            rst_n,
    input wire logic                            scl_in,
    input wire logic                            sda_out,
    input wire logic                            sda_oe,
    input wire logic [15:0]                     rest_soc_slope_limit,
    input wire logic                            pack_voltage_input_enable,
    input wire logic                            discharge_power_indicator_default,
    input wire logic [gcr_pkg::CELLS-1:0][1:0] cell_sensor_select,
    input wire logic [gcr_pkg::CELLS-1:0][2:0] cell_sensor_number
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic [1:0] ens;
    logic       num_ok;
    // Watched enables and the selector to number relation
    always_comb
    begin
        ens = {pack_voltage_input_enable, discharge_power_indicator_default};
        num_ok = 1'b1;
        for (int i = 0; i < gcr_pkg::CELLS; i++)
            if (cell_sensor_number[i] != {1'b0, cell_sensor_select[i]} + 3'h1)
                num_ok = 1'b0;
    end
    a_reset_slope: assert property ($rose(rst_n) |-> rest_soc_slope_limit == 16'h0014)
        else $error("slope not at default after reset");
    a_reset_fields: assert property ($rose(rst_n) |-> ens == 2'h3 && cell_sensor_select == '0)
        else $error("control or selector not at default after reset");
    a_number_offset: assert property (num_ok)
        else $error("sensor number is not selector plus one");
    a_sda_level: assert property (sda_oe |-> !sda_out)
        else $error("data pin driven high");
    a_sda_quiet: assert property ($rose(sda_oe) |-> !scl_in)
        else $error("data pin taken while clock high");
    a_slope_quiet: assert property (!$stable(rest_soc_slope_limit) |-> !scl_in && $past(!scl_in, 3))
        else $error("slope changed outside a write slot");
    a_ctrl_quiet: assert property (!$stable(ens) |-> !scl_in && $past(!scl_in, 3))
        else $error("control changed outside a write slot");
    a_select_quiet: assert property (!$stable(cell_sensor_select) |-> ##0 !scl_in ##0 $past(!scl_in, 3))
        else $error("selector changed outside a write slot");
    c_ack: cover property ($rose(sda_oe));
    c_slope: cover property (!$stable(rest_soc_slope_limit));
    c_sel: cover property (cell_sensor_select[3] == 2'h3);
endmodule : gcr_props
bind gcr_top gcr_props chk_u (.*);
`default_nettype wire

// [verif/tb.sv]
// Testbench: register traffic over the two-wire port, checked at pins and by readback.
// Assumes the design's default bus address 0x08.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic sys_clk, rst_n;
    wire scl, sda_h, sda_oe, sda_out;
    wire sda = (sda_oe ? sda_out : 1'b1) & sda_h; // Open-drain wire, pulled up
    wire [15:0] slope;
    wire [12:0] ens;
    wire [6:0][1:0] sel;
    wire [6:0][2:0] num;
    int bad_count = 0, check_count = 0;
    logic [8:0] q;
    logic [7:0] rb;
    logic [31:0] w, m;
    logic [15:0] ra[9] = '{16'h1008, 16'h1009, 16'h1100, 16'h1101, 16'h1102,
                           16'h1103, 16'h1200, 16'h1201, 16'h1300};
    logic [7:0] rv[9] = '{8'h14, 8'h00, 8'h8f, 8'hfc, 8'h0c, 8'h00, 8'h00, 8'h00, 8'h00};
    gcr_host host_u (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_o(sda_h));
    gcr_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .rest_soc_slope_limit(slope),
        .pack_voltage_input_enable(ens[0]), .pack_current_input_enable(ens[1]),
        .cell_current_input_enable(ens[2]), .charge_counter_input_enable(ens[3]),
        .health_learning_enable(ens[4]), .charge_constant_current_learn_enable(ens[5]),
        .charge_termination_learn_enable(ens[6]),
        .charge_constant_voltage_learn_enable(ens[7]),
        .discharge_average_learn_enable(ens[8]), .discharge_termination_learn_enable(ens[9]),
        .discharge_termination_continuous_enable(ens[10]),
        .charge_power_indicator_default(ens[11]),
        .discharge_power_indicator_default(ens[12]),
        .cell_sensor_select(sel), .cell_sensor_number(num));
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
            bad_count++;
        end
    endtask : chk
    task automatic results;
        if (bad_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    task automatic do_reset;
        rst_n = 1'b0; repeat (2) @(negedge sys_clk); rst_n = 1'b1; repeat (6) @(negedge sys_clk);
        chk("slope", 16'h0014, slope);
        chk("enables", 13'h1fff, ens);
        chk("select", 14'h0000, sel);
        chk("number", 21'h049249, num);
    endtask : do_reset
    // Write the device address, then the pointer high byte first
    task automatic ptr(input logic [15:0] a);
        host_u.start(); host_u.xfer(9'h021, q); chk("ack", 0, q[0]);
        host_u.xfer({a[15:8], 1'b1}, q); host_u.xfer({a[7:0], 1'b1}, q); chk("ack", 0, q[0]);
    endtask : ptr
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        ptr(a); host_u.xfer({d, 1'b1}, q); chk("ack", 0, q[0]); host_u.stop();
    endtask : wr
    // Read one byte, closed by a host NACK
    task automatic rchk(input logic [15:0] a, input logic [7:0] e);
        ptr(a); host_u.start(); host_u.xfer(9'h023, q); chk("ack", 0, q[0]);
        host_u.xfer(9'h1ff, q); rb = q[8:1]; host_u.stop(); chk("readback", e, rb);
    endtask : rchk
    initial
    begin
        #500us;
        bad_count++;
        results();
    end
    initial
    begin
        do_reset();
        // Reset values by readback, with an unmapped byte last
        for (int i = 0; i < 9; i++)
            rchk(ra[i], rv[i]);
        // Two complementary control words; undefined bits must drop
        for (int p = 0; p < 2; p++)
        begin
            w = p ? ~32'h0008_a40a : 32'h0008_a40a;
            m = w & 32'h000c_fc8f;
            for (int k = 0; k < 4; k++)
                wr(16'h1100 + 16'(k), w[8*k+:8]);
            chk("enables", p ? 13'h0ad5 : 13'h152a, ens);
            for (int k = 0; k < 4; k++)
                rchk(16'h1100 + 16'(k), m[8*k+:8]);
        end
        ptr(16'h1008); host_u.xfer(9'h069, q); host_u.xfer(9'h025, q); host_u.stop();
        chk("slope", 16'h1234, slope);
        ptr(16'h1008); host_u.start(); host_u.xfer(9'h023, q); host_u.xfer(9'h1fe, q);
        rb = q[8:1]; host_u.xfer(9'h1ff, q); host_u.stop();
        chk("burst", 16'h1234, {q[8:1], rb});
        // Selector values never above sensor 4, the largest pack setting
        wr(16'h1200, 8'he4); wr(16'h1201, 8'hff);
        chk("select", 14'h3fe4, sel);
        chk("number", 21'h1248d1, num);
        rchk(16'h1201, 8'h3f);
        // Foreign bus address is not acknowledged
        host_u.start(); host_u.xfer(9'h045, q); chk("nack", 1, q[0]); host_u.stop();
        do_reset();
        results();
    end
endmodule : tb
`default_nettype wire
